// ---- bpr_defs.vh ----
`ifndef BPR_DEFS_VH
`define BPR_DEFS_VH
// register byte offsets
`define BPR_CTRL 8'h00
`define BPR_CMD 8'h04
`define BPR_STATUS 8'h08
`define BPR_RP_X 8'h0c
`define BPR_RP_Y 8'h10
`define BPR_RP_Z 8'h14
`define BPR_RP_W 8'h18
`define BPR_RP_VALID 8'h1c
`define BPR_ZOOM 8'h20
`define BPR_ORG_X 8'h24
`define BPR_ORG_Y 8'h28
`define BPR_INC_X 8'h2c
`define BPR_INC_Y 8'h30
`define BPR_SIZE 8'h34
`define BPR_RP_COLOR 8'h38
`define BPR_RP_DEPTH 8'h3c
`define BPR_RP_FOG 8'h40
`define BPR_RP_TEX 8'h44
`define BPR_STIP_PTR 8'h48
`define BPR_STIP_DATA 8'h4c
`define BPR_INT_STAT 8'h50
`define BPR_INT_EN 8'h54
`define BPR_INT_CLR 8'h58
// field positions
`define BPR_CTRL_MS_BIT 0
`define BPR_CTRL_CNT_LSB 4
`define BPR_CTRL_CNT_MSB 7
`define BPR_CMD_STIP_BIT 0
`define BPR_CMD_RECT_BIT 1
`define BPR_EV_DONE 0
`define BPR_EV_IGNORED 1
`define BPR_EV_INCOMPLETE 2
`define BPR_EV_UNSUPPORTED 3
`define BPR_NUM_EV 4
// fixed point and sampling
`define BPR_FRAC 8
`define BPR_FRAC_ZERO 8'h00
`define BPR_ZOOM_ONE 16'h0100
`define BPR_STORE_COUNT_MS 4'h1
`define BPR_NS 4
`define BPR_SX0 8'h60
`define BPR_SY0 8'h20
`define BPR_SX1 8'he0
`define BPR_SY1 8'h60
`define BPR_SX2 8'h20
`define BPR_SY2 8'ha0
`define BPR_SX3 8'ha0
`define BPR_SY3 8'he0
// reset values
`define BPR_ZOOM_RST 32'h01000100
`endif

// ---- bpr_rasterizer.v ----
`timescale 1ns/1ns
`include "bpr_defs.vh"
module bpr_rasterizer #(
	parameter STIP_AW = 6
) (
	input wire clk_sys,
	input wire arst_n,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	input wire target_complete,
	input wire grp_valid,
	output reg grp_ready,
	input wire [31:0] grp_color,
	input wire [31:0] grp_depth,
	input wire grp_has_color,
	input wire grp_has_depth,
	output reg frag_valid,
	input wire frag_ready,
	output reg [15:0] frag_x,
	output reg [15:0] frag_y,
	output reg [`BPR_NS-1:0] frag_cov,
	output reg [31:0] frag_color,
	output reg [31:0] frag_depth,
	output reg [31:0] frag_fog,
	output reg [31:0] frag_tex
);

localparam S_IDLE = 3'd0;
localparam S_CELL = 3'd1;
localparam S_RECT = 3'd2;
localparam S_WALK = 3'd3;
localparam S_NEXT = 3'd4;
localparam S_DONE = 3'd5;

////////////////////////////////////////////////////////////////////////
// software-visible state
reg ms_en_reg;
reg [3:0] store_cnt_reg;
reg signed [31:0] rp_x_reg;
reg signed [31:0] rp_y_reg;
reg [31:0] rp_z_reg;
reg [31:0] rp_w_reg;
reg rp_valid_reg;
reg [31:0] zoom_reg;
reg signed [31:0] org_x_reg;
reg signed [31:0] org_y_reg;
reg signed [31:0] inc_x_reg;
reg signed [31:0] inc_y_reg;
reg [15:0] size_w_reg;
reg [15:0] size_h_reg;
reg [31:0] rp_color_reg;
reg [31:0] rp_depth_reg;
reg [31:0] rp_fog_reg;
reg [31:0] rp_tex_reg;
reg [STIP_AW-1:0] stip_ptr_reg;
reg [`BPR_NUM_EV-1:0] int_stat_reg;
reg [`BPR_NUM_EV-1:0] int_en_reg;
reg [31:0] stip_mem [0:(1<<STIP_AW)-1];

// engine state
reg [2:0] state_reg;
reg is_rect_reg;
reg ms_reg;
reg [15:0] cell_n_reg;
reg [15:0] cell_m_reg;
reg [15:0] bit_idx_reg;
reg signed [31:0] base_x_reg;
reg signed [31:0] base_y_reg;
reg signed [15:0] zx_reg;
reg signed [15:0] zy_reg;
reg signed [31:0] min_x_reg;
reg signed [31:0] max_x_reg;
reg signed [31:0] min_y_reg;
reg signed [31:0] max_y_reg;
reg [23:0] px_lo_reg;
reg [23:0] px_hi_reg;
reg [23:0] py_hi_reg;
reg [23:0] px_reg;
reg [23:0] py_reg;
reg [31:0] cur_color_reg;
reg [31:0] cur_depth_reg;

wire busy = (state_reg != S_IDLE);
wire ms_active = ms_en_reg && (store_cnt_reg == `BPR_STORE_COUNT_MS);
wire apb_setup = psel && !penable;
wire apb_wr = psel && penable && pready && pwrite && !pslverr;
wire rp_update = (state_reg == S_DONE) && !frag_valid && !is_rect_reg;
wire draw_done = (state_reg == S_DONE) && !frag_valid;

////////////////////////////////////////////////////////////////////////
// apb decode: answer is prepared in the setup cycle, so no wait states
reg [31:0] rd_data;
reg rd_hit;
always @* begin
	rd_hit = 1'b1;
	rd_data = 32'h00000000;
	case (paddr)
	`BPR_CTRL: rd_data = {24'h000000, store_cnt_reg, 3'b000, ms_en_reg};
	`BPR_CMD: rd_data = 32'h00000000;
	`BPR_STATUS: rd_data = {29'h00000000, ms_active, rp_valid_reg, busy};
	`BPR_RP_X: rd_data = rp_x_reg;
	`BPR_RP_Y: rd_data = rp_y_reg;
	`BPR_RP_Z: rd_data = rp_z_reg;
	`BPR_RP_W: rd_data = rp_w_reg;
	`BPR_RP_VALID: rd_data = {31'h00000000, rp_valid_reg};
	`BPR_ZOOM: rd_data = zoom_reg;
	`BPR_ORG_X: rd_data = org_x_reg;
	`BPR_ORG_Y: rd_data = org_y_reg;
	`BPR_INC_X: rd_data = inc_x_reg;
	`BPR_INC_Y: rd_data = inc_y_reg;
	`BPR_SIZE: rd_data = {size_h_reg, size_w_reg};
	`BPR_RP_COLOR: rd_data = rp_color_reg;
	`BPR_RP_DEPTH: rd_data = rp_depth_reg;
	`BPR_RP_FOG: rd_data = rp_fog_reg;
	`BPR_RP_TEX: rd_data = rp_tex_reg;
	`BPR_STIP_PTR: rd_data = {{(32-STIP_AW){1'b0}}, stip_ptr_reg};
	`BPR_STIP_DATA: rd_data = 32'h00000000;
	`BPR_INT_STAT: rd_data = {{(32-`BPR_NUM_EV){1'b0}}, int_stat_reg};
	`BPR_INT_EN: rd_data = {{(32-`BPR_NUM_EV){1'b0}}, int_en_reg};
	`BPR_INT_CLR: rd_data = 32'h00000000;
	default: rd_hit = 1'b0;
	endcase
end

// writes that would disturb a draw in flight are refused with an error
wire wr_locked = busy && pwrite && (paddr != `BPR_INT_EN) && (paddr != `BPR_INT_CLR);

always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else begin
		pready <= apb_setup;
		pslverr <= apb_setup && (!rd_hit || wr_locked);
		prdata <= (apb_setup && !pwrite) ? rd_data : 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////
// command decode and events
wire cmd_wr = apb_wr && (paddr == `BPR_CMD);
wire cmd_stip = cmd_wr && pwdata[`BPR_CMD_STIP_BIT];
wire cmd_rect = cmd_wr && !pwdata[`BPR_CMD_STIP_BIT] && pwdata[`BPR_CMD_RECT_BIT];
wire ev_incomplete = cmd_stip && !target_complete;
wire ev_unsup = cmd_rect && !ms_active;
wire ev_ignored = (cmd_stip && target_complete && !rp_valid_reg) ||
	(cmd_rect && ms_active && !rp_valid_reg);
wire start_stip = cmd_stip && target_complete && rp_valid_reg;
wire start_rect = cmd_rect && ms_active && rp_valid_reg;
wire [`BPR_NUM_EV-1:0] ev_set = {ev_unsup, ev_incomplete, ev_ignored, draw_done};
wire [`BPR_NUM_EV-1:0] ev_clr = (apb_wr && (paddr == `BPR_INT_CLR)) ?
	pwdata[`BPR_NUM_EV-1:0] : {`BPR_NUM_EV{1'b0}};

// status is sticky; a new event beats a clear in the same cycle
always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		int_stat_reg <= {`BPR_NUM_EV{1'b0}};
		int_en_reg <= {`BPR_NUM_EV{1'b0}};
		irq <= 1'b0;
	end else begin
		int_stat_reg <= (int_stat_reg & ~ev_clr) | ev_set;
		if (apb_wr && (paddr == `BPR_INT_EN))
			int_en_reg <= pwdata[`BPR_NUM_EV-1:0];
		irq <= |(int_stat_reg & int_en_reg);
	end
end

////////////////////////////////////////////////////////////////////////
// parameter registers and raster position
always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		ms_en_reg <= 1'b0;
		store_cnt_reg <= 4'h0;
		rp_x_reg <= 32'h00000000;
		rp_y_reg <= 32'h00000000;
		rp_z_reg <= 32'h00000000;
		rp_w_reg <= 32'h00000000;
		rp_valid_reg <= 1'b0;
		zoom_reg <= `BPR_ZOOM_RST;
		org_x_reg <= 32'h00000000;
		org_y_reg <= 32'h00000000;
		inc_x_reg <= 32'h00000000;
		inc_y_reg <= 32'h00000000;
		size_w_reg <= 16'h0000;
		size_h_reg <= 16'h0000;
		rp_color_reg <= 32'h00000000;
		rp_depth_reg <= 32'h00000000;
		rp_fog_reg <= 32'h00000000;
		rp_tex_reg <= 32'h00000000;
		stip_ptr_reg <= {STIP_AW{1'b0}};
	end else if (rp_update) begin
		rp_x_reg <= rp_x_reg + inc_x_reg;
		rp_y_reg <= rp_y_reg + inc_y_reg;
	end else if (apb_wr) begin
		case (paddr)
		`BPR_CTRL: begin
			ms_en_reg <= pwdata[`BPR_CTRL_MS_BIT];
			store_cnt_reg <= pwdata[`BPR_CTRL_CNT_MSB:`BPR_CTRL_CNT_LSB];
		end
		`BPR_RP_X: rp_x_reg <= pwdata;
		`BPR_RP_Y: rp_y_reg <= pwdata;
		`BPR_RP_Z: rp_z_reg <= pwdata;
		`BPR_RP_W: rp_w_reg <= pwdata;
		`BPR_RP_VALID: rp_valid_reg <= pwdata[0];
		`BPR_ZOOM: zoom_reg <= pwdata;
		`BPR_ORG_X: org_x_reg <= pwdata;
		`BPR_ORG_Y: org_y_reg <= pwdata;
		`BPR_INC_X: inc_x_reg <= pwdata;
		`BPR_INC_Y: inc_y_reg <= pwdata;
		`BPR_SIZE: begin
			size_w_reg <= pwdata[15:0];
			size_h_reg <= pwdata[31:16];
		end
		`BPR_RP_COLOR: rp_color_reg <= pwdata;
		`BPR_RP_DEPTH: rp_depth_reg <= pwdata;
		`BPR_RP_FOG: rp_fog_reg <= pwdata;
		`BPR_RP_TEX: rp_tex_reg <= pwdata;
		`BPR_STIP_PTR: stip_ptr_reg <= pwdata[STIP_AW-1:0];
		`BPR_STIP_DATA: stip_ptr_reg <= stip_ptr_reg + 1'b1;
		default: stip_ptr_reg <= stip_ptr_reg;
		endcase
	end
end

// stipple store holds the raw unpacked bits, bit 0 of a word first
always @(posedge clk_sys) begin
	if (apb_wr && (paddr == `BPR_STIP_DATA))
		stip_mem[stip_ptr_reg] <= pwdata;
end

////////////////////////////////////////////////////////////////////////
// cell rectangle and per-sample coverage
wire [STIP_AW-1:0] stip_word = bit_idx_reg[STIP_AW+4:5];
wire [31:0] stip_row = stip_mem[stip_word];
wire stip_bit = stip_row[bit_idx_reg[4:0]];
wire signed [32:0] prod_x = $signed({1'b0, cell_n_reg}) * zx_reg;
wire signed [32:0] prod_y = $signed({1'b0, cell_m_reg}) * zy_reg;
wire signed [31:0] ax = base_x_reg + prod_x[31:0];
wire signed [31:0] ay = base_y_reg + prod_y[31:0];
wire signed [31:0] bx = ax + {{16{zx_reg[15]}}, zx_reg};
wire signed [31:0] by = ay + {{16{zy_reg[15]}}, zy_reg};
// negative zoom flips the corners, so order them before edge tests
wire signed [31:0] rmin_x = zx_reg[15] ? bx : ax;
wire signed [31:0] rmax_x = zx_reg[15] ? ax : bx;
wire signed [31:0] rmin_y = zy_reg[15] ? by : ay;
wire signed [31:0] rmax_y = zy_reg[15] ? ay : by;
wire signed [31:0] lo_x = rmin_x >>> `BPR_FRAC;
wire signed [31:0] hi_x = (rmax_x - 32'sd1) >>> `BPR_FRAC;
wire signed [31:0] lo_y = rmin_y >>> `BPR_FRAC;
wire signed [31:0] hi_y = (rmax_y - 32'sd1) >>> `BPR_FRAC;
wire rect_empty = (rmax_x <= rmin_x) || (rmax_y <= rmin_y);

function [7:0] samp_x;
	input integer i;
	begin
		case (i)
		0: samp_x = `BPR_SX0;
		1: samp_x = `BPR_SX1;
		2: samp_x = `BPR_SX2;
		default: samp_x = `BPR_SX3;
		endcase
	end
endfunction

function [7:0] samp_y;
	input integer i;
	begin
		case (i)
		0: samp_y = `BPR_SY0;
		1: samp_y = `BPR_SY1;
		2: samp_y = `BPR_SY2;
		default: samp_y = `BPR_SY3;
		endcase
	end
endfunction

// inclusive on the low (left, bottom) edge, exclusive on the high edge
reg [`BPR_NS-1:0] cov_ms;
reg signed [31:0] sx;
reg signed [31:0] sy;
integer k;
always @* begin
	cov_ms = {`BPR_NS{1'b0}};
	sx = 32'sd0;
	sy = 32'sd0;
	for (k = 0; k < `BPR_NS; k = k + 1) begin
		sx = $signed({px_reg, `BPR_FRAC_ZERO}) + $signed({24'h000000, samp_x(k)});
		sy = $signed({py_reg, `BPR_FRAC_ZERO}) + $signed({24'h000000, samp_y(k)});
		cov_ms[k] = (sx >= min_x_reg) && (sx < max_x_reg) &&
			(sy >= min_y_reg) && (sy < max_y_reg);
	end
end
// single-sample cells are whole pixels, so the lone sample is always hit
wire [`BPR_NS-1:0] cov = ms_reg ? cov_ms : {`BPR_NS{1'b1}};

// single-sample origin is floored; multisample keeps the fraction
wire signed [31:0] fl_x = ((rp_x_reg - org_x_reg) >>> `BPR_FRAC) <<< `BPR_FRAC;
wire signed [31:0] fl_y = ((rp_y_reg - org_y_reg) >>> `BPR_FRAC) <<< `BPR_FRAC;
wire use_ms = start_rect || ms_active;

////////////////////////////////////////////////////////////////////////
// draw engine: cells row by row from the bottom, pixels within a cell
always @(posedge clk_sys or negedge arst_n) begin
	if (!arst_n) begin
		state_reg <= S_IDLE;
		is_rect_reg <= 1'b0;
		ms_reg <= 1'b0;
		cell_n_reg <= 16'h0000;
		cell_m_reg <= 16'h0000;
		bit_idx_reg <= 16'h0000;
		base_x_reg <= 32'h00000000;
		base_y_reg <= 32'h00000000;
		zx_reg <= 16'h0000;
		zy_reg <= 16'h0000;
		min_x_reg <= 32'h00000000;
		max_x_reg <= 32'h00000000;
		min_y_reg <= 32'h00000000;
		max_y_reg <= 32'h00000000;
		px_lo_reg <= 24'h000000;
		px_hi_reg <= 24'h000000;
		py_hi_reg <= 24'h000000;
		px_reg <= 24'h000000;
		py_reg <= 24'h000000;
		cur_color_reg <= 32'h00000000;
		cur_depth_reg <= 32'h00000000;
		grp_ready <= 1'b0;
		frag_valid <= 1'b0;
		frag_x <= 16'h0000;
		frag_y <= 16'h0000;
		frag_cov <= {`BPR_NS{1'b0}};
		frag_color <= 32'h00000000;
		frag_depth <= 32'h00000000;
		frag_fog <= 32'h00000000;
		frag_tex <= 32'h00000000;
	end else begin
		if (frag_ready)
			frag_valid <= 1'b0;
		case (state_reg)
		S_IDLE: begin
			if (start_stip || start_rect) begin
				is_rect_reg <= start_rect;
				ms_reg <= use_ms;
				base_x_reg <= use_ms ? rp_x_reg : fl_x;
				base_y_reg <= use_ms ? rp_y_reg : fl_y;
				zx_reg <= start_rect ? zoom_reg[15:0] : `BPR_ZOOM_ONE;
				zy_reg <= start_rect ? zoom_reg[31:16] : `BPR_ZOOM_ONE;
				cell_n_reg <= 16'h0000;
				cell_m_reg <= 16'h0000;
				bit_idx_reg <= 16'h0000;
				if ((size_w_reg == 16'h0000) || (size_h_reg == 16'h0000)) begin
					state_reg <= S_DONE;
				end else begin
					grp_ready <= start_rect;
					state_reg <= S_CELL;
				end
			end
		end
		S_CELL: begin
			if (is_rect_reg) begin
				if (grp_valid && grp_ready) begin
					grp_ready <= 1'b0;
					cur_color_reg <= grp_has_color ? grp_color : rp_color_reg;
					cur_depth_reg <= grp_has_depth ? grp_depth : rp_depth_reg;
					state_reg <= S_RECT;
				end
			end else begin
				cur_color_reg <= rp_color_reg;
				cur_depth_reg <= rp_depth_reg;
				state_reg <= stip_bit ? S_RECT : S_NEXT;
			end
		end
		S_RECT: begin
			min_x_reg <= rmin_x;
			max_x_reg <= rmax_x;
			min_y_reg <= rmin_y;
			max_y_reg <= rmax_y;
			px_lo_reg <= lo_x[23:0];
			px_hi_reg <= hi_x[23:0];
			py_hi_reg <= hi_y[23:0];
			px_reg <= lo_x[23:0];
			py_reg <= lo_y[23:0];
			state_reg <= rect_empty ? S_NEXT : S_WALK;
		end
		S_WALK: begin
			// every covered pixel goes out on its own, even a repeat
			if (!frag_valid || frag_ready) begin
				frag_valid <= |cov;
				frag_x <= px_reg[15:0];
				frag_y <= py_reg[15:0];
				frag_cov <= cov;
				frag_color <= cur_color_reg;
				frag_depth <= cur_depth_reg;
				frag_fog <= rp_fog_reg;
				frag_tex <= rp_tex_reg;
				if (px_reg == px_hi_reg) begin
					px_reg <= px_lo_reg;
					if (py_reg == py_hi_reg)
						state_reg <= S_NEXT;
					else
						py_reg <= py_reg + 24'h000001;
				end else begin
					px_reg <= px_reg + 24'h000001;
				end
			end
		end
		S_NEXT: begin
			bit_idx_reg <= bit_idx_reg + 16'h0001;
			if (cell_n_reg == size_w_reg - 16'h0001) begin
				cell_n_reg <= 16'h0000;
				if (cell_m_reg == size_h_reg - 16'h0001) begin
					state_reg <= S_DONE;
				end else begin
					cell_m_reg <= cell_m_reg + 16'h0001;
					grp_ready <= is_rect_reg;
					state_reg <= S_CELL;
				end
			end else begin
				cell_n_reg <= cell_n_reg + 16'h0001;
				grp_ready <= is_rect_reg;
				state_reg <= S_CELL;
			end
		end
		S_DONE: begin
			// raster position moves only after the last fragment has left
			if (!frag_valid)
				state_reg <= S_IDLE;
		end
		default: state_reg <= S_IDLE;
		endcase
	end
end

endmodule

// ---- bpr_far_model.sv ----
`timescale 1ns/1ns
module bpr_far_model (
	input wire clk_sys,
	input wire arst_n,
	input wire stall,
	input wire [31:0] col_base,
	input wire [31:0] dep_base,
	input wire has_c,
	input wire has_d,
	input wire grp_ready,
	output reg grp_valid,
	output reg [31:0] grp_color,
	output reg [31:0] grp_depth,
	output reg grp_has_color,
	output reg grp_has_depth,
	output reg frag_ready
);
	reg [31:0] cnt_reg;
	////////////////////////////////////////////////////////////////
	// group k carries base+k; released lines turn inverted so stale data never matches
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			grp_valid <= 1'b0;
			grp_color <= 32'h0;
			grp_depth <= 32'h0;
			grp_has_color <= 1'b0;
			grp_has_depth <= 1'b0;
			frag_ready <= 1'b0;
			cnt_reg <= 32'h0;
		end else begin
			frag_ready <= stall ? 1'($urandom) : 1'b1; // random back-pressure
			// flags track the bench live, so a group parked between draws is never stale
			grp_has_color <= has_c;
			grp_has_depth <= has_d;
			if (grp_valid && grp_ready) begin
				grp_valid <= 1'b0;
				grp_color <= ~grp_color;
				grp_depth <= ~grp_depth;
				cnt_reg <= cnt_reg + 32'h1;
			end else if (!grp_valid) begin
				grp_valid <= 1'b1;
				grp_color <= col_base + cnt_reg;
				grp_depth <= dep_base + cnt_reg;
			end
		end
	end
endmodule

// ---- bpr_rasterizer_assertions.sv ----
`timescale 1ns/1ns
`include "bpr_defs.vh"
module bpr_checker (
	input wire clk_sys,
	input wire arst_n,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire irq,
	input wire target_complete,
	input wire grp_valid,
	input wire grp_ready,
	input wire frag_valid,
	input wire frag_ready,
	input wire [15:0] frag_x,
	input wire [15:0] frag_y,
	input wire [`BPR_NS-1:0] frag_cov,
	input wire [31:0] frag_color,
	input wire [31:0] frag_depth,
	input wire [31:0] frag_fog,
	input wire [31:0] frag_tex
);
	wire acc_w = psel && penable && pready && pwrite && !pslverr;
	wire cmd_w = acc_w && paddr == `BPR_CMD;
	wire rect_cmd = cmd_w && pwdata[1:0] == 2'b10;
	wire stip_cmd = cmd_w && pwdata[0];
	reg [7:0] ctrl_reg;
	reg rpv_reg;
	reg st_reg;
	reg [3:0] en_reg;
	reg [31:0] col_reg, dep_reg, fog_reg, tex_reg;
	wire ms_on = ctrl_reg[`BPR_CTRL_MS_BIT] && ctrl_reg[7:4] == `BPR_STORE_COUNT_MS;
	////////////////////////////////////////////////////////////////
	// shadow of accepted writes; refused ones carry pslverr and are skipped
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= 8'h00;
			rpv_reg <= 1'b0;
			st_reg <= 1'b0;
			en_reg <= 4'h0;
			col_reg <= 32'h0;
			dep_reg <= 32'h0;
			fog_reg <= 32'h0;
			tex_reg <= 32'h0;
		end else if (acc_w) begin
			case (paddr)
			`BPR_CTRL: ctrl_reg <= pwdata[7:0];
			`BPR_RP_VALID: rpv_reg <= pwdata[0];
			`BPR_INT_EN: en_reg <= pwdata[3:0];
			`BPR_RP_COLOR: col_reg <= pwdata;
			`BPR_RP_DEPTH: dep_reg <= pwdata;
			`BPR_RP_FOG: fog_reg <= pwdata;
			`BPR_RP_TEX: tex_reg <= pwdata;
			`BPR_CMD: st_reg <= pwdata[0];
			default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_pready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ms_gate_rect: assert property (rect_cmd && !ms_on |=> !grp_ready [*8])
		else $error("rect drawn outside multisample");
	a_rect_rp_invalid: assert property (rect_cmd && !rpv_reg |=> !grp_ready [*8])
		else $error("rect drawn with invalid position");
	a_stip_rp_invalid: assert property (stip_cmd && !rpv_reg |=> !frag_valid [*8])
		else $error("stipple drawn with invalid position");
	a_incomplete_irq: assert property (stip_cmd && !target_complete && en_reg[2]
		|-> ##[1:3] irq)
		else $error("incomplete target not flagged");
	a_cov_nonzero: assert property (frag_valid |-> frag_cov != 4'h0)
		else $error("fragment without coverage");
	a_single_full_cov: assert property (frag_valid && !ms_on |-> frag_cov == 4'hf)
		else $error("single sample coverage not full");
	a_fog_tex_rp: assert property (frag_valid |-> frag_fog == fog_reg && frag_tex == tex_reg)
		else $error("fog or texture not from position");
	a_stip_rp_data: assert property (frag_valid && st_reg
		|-> frag_color == col_reg && frag_depth == dep_reg)
		else $error("stipple data not from position");
	a_frag_hold: assert property (frag_valid && !frag_ready
		|=> frag_valid && $stable(frag_x) && $stable(frag_y) && $stable(frag_cov))
		else $error("fragment changed while stalled");
	a_grp_once: assert property (grp_valid && grp_ready |=> !grp_ready)
		else $error("group ready held after take");
	a_irq_masked: assert property (en_reg == 4'h0 |=> !irq)
		else $error("irq while all masked");
	c_partial_cov: cover property (frag_valid && frag_ready && frag_cov != 4'hf);
	c_grp_take: cover property (grp_valid && grp_ready);
	c_irq: cover property (irq);
endmodule
bind bpr_rasterizer bpr_checker chk_u (
	.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.target_complete(target_complete), .grp_valid(grp_valid), .grp_ready(grp_ready),
	.frag_valid(frag_valid), .frag_ready(frag_ready), .frag_x(frag_x), .frag_y(frag_y),
	.frag_cov(frag_cov), .frag_color(frag_color), .frag_depth(frag_depth),
	.frag_fog(frag_fog), .frag_tex(frag_tex)
);

// ---- bitmap_pixel_rect_rasterizer_tb_top.sv ----
`timescale 1ns/1ns
`include "bpr_defs.vh"
`define CHK(n,x,g) begin checks++; if ((g) !== (x)) begin fails++; \
	$display("FAIL %s exp %0h got %0h", n, x, g); end end
module bitmap_pixel_rect_rasterizer_tb_top;
	reg clk_sys, arst_n, psel, penable, pwrite, target_complete, stall, has_c, has_d, e;
	reg [7:0] paddr;
	reg [31:0] pwdata, col_base, dep_base, r, c, d, zm;
	wire [31:0] prdata, grp_color, grp_depth, frag_color, frag_depth, frag_fog, frag_tex;
	wire pready, pslverr, irq, grp_valid, grp_ready, grp_has_color, grp_has_depth;
	wire frag_valid, frag_ready;
	wire [15:0] frag_x, frag_y;
	wire [3:0] frag_cov;
	integer fails, checks, i, j, g;
	reg [99:0] exq[$];
	reg [99:0] ef;
	reg [15:0] t, x;
	reg [3:0] cv;
	// tc,rpv | ctrl | cmd | expected event bits
	reg [15:0] tbl [0:5] = '{16'h4014, 16'h8012, 16'hc028, 16'h8462, 16'hc068, 16'hc868};
	bpr_rasterizer #(.STIP_AW(2)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .target_complete(target_complete),
		.grp_valid(grp_valid), .grp_ready(grp_ready), .grp_color(grp_color),
		.grp_depth(grp_depth), .grp_has_color(grp_has_color), .grp_has_depth(grp_has_depth),
		.frag_valid(frag_valid), .frag_ready(frag_ready), .frag_x(frag_x), .frag_y(frag_y),
		.frag_cov(frag_cov), .frag_color(frag_color), .frag_depth(frag_depth),
		.frag_fog(frag_fog), .frag_tex(frag_tex));
	bpr_far_model far_u (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall),
		.col_base(col_base), .dep_base(dep_base), .has_c(has_c), .has_d(has_d),
		.grp_ready(grp_ready), .grp_valid(grp_valid), .grp_color(grp_color),
		.grp_depth(grp_depth), .grp_has_color(grp_has_color), .grp_has_depth(grp_has_depth),
		.frag_ready(frag_ready));
	////////////////////////////////////////////////////////////////
	task give_verdict;
		begin
			$display("checks %0d fails %0d", checks, fails);
			if (fails == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// one apb transfer; result left in r and e
	task apb(input [7:0] a, input w, input [31:0] dt);
		integer k;
		begin
			@(posedge clk_sys);
			paddr <= a;
			pwrite <= w;
			pwdata <= dt;
			psel <= 1'b1;
			@(posedge clk_sys);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge clk_sys);
				k++;
			end while (pready !== 1'b1 && k < 50);
			if (k >= 50) begin
				fails++;
				give_verdict;
			end
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [31:0] dt);
		apb(a, 1'b1, dt);
	endtask
	task rdc(input [7:0] a, input [31:0] xv);
		begin
			apb(a, 1'b0, 32'h0);
			`CHK("read", xv, r)
		end
	endtask
	task push(input [15:0] px, input [15:0] py, input [3:0] pc, input [31:0] cl, input [31:0] dp);
		exq.push_back({px, py, pc, cl, dp});
	endtask
	// start a draw, poke a register while busy, wait for idle, check done event
	task draw(input [31:0] cmd);
		integer k;
		begin
			wr(`BPR_CMD, cmd);
			wr(`BPR_RP_FOG, 32'h0);
			`CHK("busy write err", 1'b1, e)
			k = 0;
			do begin
				apb(`BPR_STATUS, 1'b0, 32'h0);
				k++;
			end while (r[0] !== 1'b0 && k < 500);
			if (k >= 500) begin
				fails++;
				give_verdict;
			end
			`CHK("frags missing", 0, exq.size())
			rdc(`BPR_INT_STAT, 32'h1);
			`CHK("irq done", 1'b1, irq)
			wr(`BPR_INT_CLR, 32'hf);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// monitor: every accepted fragment must match the oldest note
	always @(posedge clk_sys) begin
		if (frag_valid === 1'b1 && frag_ready === 1'b1) begin
			ef = exq.size() ? exq.pop_front() : 100'h0;
			`CHK("frag", ef, {frag_x, frag_y, frag_cov, frag_color, frag_depth})
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		{arst_n, psel, penable, pwrite, target_complete, has_c, has_d} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stall = 1'b1;
		fails = 0;
		checks = 0;
		g = 0;
		r = $urandom(32'he9a4);
		col_base = $urandom;
		dep_base = $urandom;
		c = $urandom;
		d = $urandom;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdc(`BPR_ZOOM, `BPR_ZOOM_RST);
		rdc(`BPR_INT_STAT, 32'h0);
		apb(8'hfc, 1'b0, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		wr(`BPR_INT_EN, 32'hf);
		target_complete <= 1'b1;
		wr(`BPR_RP_COLOR, c);
		wr(`BPR_RP_DEPTH, d);
		wr(`BPR_RP_FOG, $urandom);
		wr(`BPR_RP_TEX, $urandom);
		wr(`BPR_RP_X, 32'ha80);
		wr(`BPR_RP_Y, 32'h300);
		wr(`BPR_RP_Z, 32'h1234);
		wr(`BPR_RP_VALID, 32'h1);
		wr(`BPR_ORG_X, 32'h40);
		wr(`BPR_ORG_Y, 32'h180);
		wr(`BPR_INC_X, 32'h200);
		wr(`BPR_INC_Y, 32'hfffffe00);
		wr(`BPR_SIZE, 32'h00020002);
		wr(`BPR_STIP_PTR, 32'h0);
		wr(`BPR_STIP_DATA, 32'h9);
		push(16'd10, 16'd1, 4'hf, c, d);
		push(16'd11, 16'd2, 4'hf, c, d);
		draw(32'h1);
		rdc(`BPR_RP_X, 32'hc80);
		rdc(`BPR_RP_Y, 32'h100);
		rdc(`BPR_RP_Z, 32'h1234);
		for (i = 0; i < 6; i++) begin
			t = tbl[i];
			target_complete <= t[15];
			wr(`BPR_RP_VALID, {31'h0, t[14]});
			wr(`BPR_CTRL, {24'h0, t[13:6]});
			wr(`BPR_CMD, {30'h0, t[5:4]});
			rdc(`BPR_INT_STAT, {28'h0, t[3:0]});
			`CHK("irq event", 1'b1, irq)
			wr(`BPR_INT_CLR, 32'hf);
			rdc(`BPR_RP_X, 32'hc80);
		end
		// masked event still latches status but keeps irq low
		wr(`BPR_INT_EN, 32'h0);
		wr(`BPR_CMD, 32'h2);
		rdc(`BPR_INT_STAT, 32'h8);
		`CHK("irq masked", 1'b0, irq)
		wr(`BPR_INT_CLR, 32'hf);
		wr(`BPR_INT_EN, 32'hf);
		wr(`BPR_CTRL, 32'h11);
		wr(`BPR_RP_X, 32'h400);
		wr(`BPR_RP_Y, 32'h600);
		wr(`BPR_SIZE, 32'h00010002);
		rdc(`BPR_STATUS, 32'h6);
		// zoom 1, zoom -1 in x, zoom 0.5 in x (two fragments on one pixel)
		for (i = 0; i < 3; i++) begin
			has_c <= (i != 1);
			has_d <= (i == 1);
			zm = (i == 0) ? 32'h01000100 : (i == 1) ? 32'h0100ff00 : 32'h01000080;
			wr(`BPR_ZOOM, zm);
			for (j = 0; j < 2; j++) begin
				x = (i == 0) ? 4 + j : (i == 1) ? 3 - j : 4;
				cv = (i == 2) ? (j ? 4'ha : 4'h5) : 4'hf;
				push(x, 16'd6, cv, (i == 1) ? c : col_base + g, (i == 1) ? dep_base + g : d);
				g++;
			end
			draw(32'h2);
		end
		wr(`BPR_RP_X, 32'h480);
		wr(`BPR_STIP_PTR, 32'h0);
		wr(`BPR_STIP_DATA, 32'h2);
		push(16'd5, 16'd6, 4'ha, c, d);
		push(16'd6, 16'd6, 4'h5, c, d);
		draw(32'h1);
		rdc(`BPR_RP_X, 32'h680);
		give_verdict;
	end
endmodule
